// ### core/track_serializer.sv
// one track stream: 24-bit shifter, running frame check sequence and line coder
// assumes shared half-bit enables from the formatter; all tracks see the same ones
module track_serializer (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic active_i,
   input wire logic mid_en_i,
   input wire logic bit_en_i,
   input wire logic load_i,
   input wire logic [23:0] word_i,
   input wire logic acc_i,
   input wire logic crc_clr_i,
   input wire logic scramble_i,
   output logic line_o,
   output logic [15:0] crc_o
);

   typedef struct packed {
      logic [23:0] sr;
      logic acc;
      logic [15:0] crc;
      logic [14:0] hist;
      logic line;
   } ser_state_t;

   ser_state_t s;
   ser_state_t next_s;
   logic new_bit;
   logic scr_bit;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      logic fb;
      fb = b ^ c[15];
      crc_step = {c[14:0], 1'b0} ^ (fb ? tsf_pkg::CRC_POLY : 16'h0000);
   endfunction

   // includes the bit now on the line so a CRC word loaded this edge is complete
   assign crc_o = s.acc ? crc_step(s.crc, s.sr[23]) : s.crc;
   assign line_o = s.line;

   always_comb begin
      next_s = s;
      new_bit = load_i ? word_i[23] : s.sr[22];
      scr_bit = new_bit ^ s.hist[13] ^ s.hist[14];
      if (!active_i) begin
         next_s = '0;
      end else if (bit_en_i) begin
         next_s.crc = crc_clr_i ? tsf_pkg::CRC_INIT : crc_o;
         if (load_i) begin
            next_s.sr = word_i;
            next_s.acc = acc_i;
         end else begin
            next_s.sr = {s.sr[22:0], 1'b0};
         end
         if (scramble_i) begin
            next_s.hist = {s.hist[13:0], scr_bit};
            next_s.line = scr_bit;
         end else begin
            next_s.line = new_bit;
         end
      end else if (mid_en_i && !scramble_i) begin
         // bi-phase level: second half of every cell is the inverse
         next_s.line = ~s.sr[23];
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule // track_serializer

// ### core/track_spread_formatter.sv
// track spread PCM formatter: monitor intake, word buffer, framing and register slave
// assumes a classic Wishbone master and a 1553 word decoder on the same clock
module track_spread_formatter #(
   parameter int FIFO_DEPTH = 16,
   parameter int FIFO_AW = 4
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire tsf_pkg::mon_word_t mon_i,
   output logic [tsf_pkg::MAX_TRACKS-1:0] track_line_o,
   output logic bit_clk_o,
   output logic overflow_o
);

   localparam int NT = tsf_pkg::MAX_TRACKS;

   // -----------------------------------------------------------------
   // parameter check
   // -----------------------------------------------------------------
   if (FIFO_AW < 1 || FIFO_AW > 7 || FIFO_DEPTH != (1 << FIFO_AW)) begin : g_bad_fifo
      $error("fifo depth must be a power of two from 2 to 128");
   end

   typedef struct packed {
      tsf_pkg::run_state_t st;
      logic ack;
      logic [31:0] rdat;
      tsf_pkg::ctrl_reg_t ctrl;
      logic [8:0] frame_len;
      logic [15:0] half_div;
      logic [15:0] t_hi;
      logic [15:0] t_lo;
      logic [15:0] t_us;
      logic ovf_sticky;
      logic ovf_pending;
      logic [15:0] err_cnt;
      logic [15:0] div_cnt;
      logic phase;
      logic [4:0] word_bit;
      logic [8:0] word_idx;
      logic [FIFO_DEPTH-1:0][23:0] mem;
      logic [FIFO_AW-1:0] wp;
      logic [FIFO_AW-1:0] rp;
      logic [FIFO_AW:0] cnt;
   } state_t;

   state_t s;
   state_t next_s;

   logic running;
   logic half_en;
   logic mid_en;
   logic bit_en;
   logic [4:0] stagger;
   logic [NT-1:0] load;
   logic [1:0] lk;
   logic [10:0] slot;
   logic [23:0] load_word;
   logic load_acc;
   logic load_clr;
   logic pop;
   logic push;
   logic [23:0] push_word;
   logic [NT-1:0][15:0] crc;
   logic wb_hit;
   logic wb_wr;
   logic [31:0] wr_merge;
   logic [31:0] cur_reg;
   logic mon_err;
   logic [3:0] mon_label;
   tsf_pkg::status_reg_t status;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [23:0] tag_word(input logic [3:0] id, input logic par_en,
                                            input logic [3:0] label, input logic [15:0] info);
      tsf_pkg::tagged_word_t w;
      w.ident = id;
      w.label = label;
      w.info = info;
      // parity option trades the top ident bit for odd parity over the word
      if (par_en) begin
         w.ident[3] = ~^{w.ident[2:0], w.label, w.info};
      end
      tag_word = w;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction

   // -----------------------------------------------------------------
   // track serializers, one per possible track, on the common bit enables
   // -----------------------------------------------------------------
   for (genvar k = 0; k < NT; k++) begin : g_track
      track_serializer u_ser (
         .clk_i(clk_i),
         .resetn_i(resetn_i),
         .active_i(running && (k <= int'(s.ctrl.tk_m1))),
         .mid_en_i(mid_en),
         .bit_en_i(bit_en),
         .load_i(load[k]),
         .word_i(load_word),
         .acc_i(load_acc),
         .crc_clr_i(load_clr),
         .scramble_i(s.ctrl.scramble),
         .line_o(track_line_o[k]),
         .crc_o(crc[k])
      );
   end

   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.rdat;
   assign bit_clk_o = s.phase;
   assign overflow_o = s.ovf_sticky;

   always_comb begin
      next_s = s;
      running = (s.st == tsf_pkg::ST_RUN);

      // -----------------------------------------------------------------
      // bit timing: one divider, half-bit enables shared by every track
      // -----------------------------------------------------------------
      half_en = running && (s.div_cnt == s.half_div);
      mid_en = half_en && !s.phase;
      bit_en = half_en && s.phase;
      stagger = 5'(tsf_pkg::WORD_BITS / (int'(s.ctrl.tk_m1) + 1));

      // each track loads at its own offset inside the shared word period
      load = '0;
      lk = '0;
      for (int k = 0; k < NT; k++) begin
         if (bit_en && k <= int'(s.ctrl.tk_m1) && s.word_bit == 5'(k * int'(stagger))) begin
            load[k] = 1'b1;
            lk = 2'(k);
         end
      end

      // position of this word in the rotation after the sync words
      slot = 11'((int'(s.word_idx) - 1) * (int'(s.ctrl.tk_m1) + 1) + int'(lk));

      pop = 1'b0;
      load_acc = 1'b1;
      load_clr = 1'b0;
      if (s.word_idx == '0) begin
         load_word = tsf_pkg::SYNC_WORD;
         load_acc = 1'b0;
         load_clr = 1'b1;
      end else if (s.ctrl.crc_en && s.word_idx == s.frame_len - 9'd1) begin
         load_word = tag_word(s.ctrl.bus_id, s.ctrl.par_en, tsf_pkg::LBL_CRC, crc[lk]);
         load_acc = 1'b0;
      end else if (s.ctrl.ft_en && slot < 11'(tsf_pkg::TIME_WORDS)) begin
         // slot 0/1/2 land on streams one/two/three when four tracks are used
         case (slot[1:0])
            2'b00: load_word = tag_word(s.ctrl.bus_id, s.ctrl.par_en,
                                        tsf_pkg::LBL_TIME_HI, s.t_hi);
            2'b01: load_word = tag_word(s.ctrl.bus_id, s.ctrl.par_en,
                                        tsf_pkg::LBL_TIME_LO, s.t_lo);
            default: load_word = tag_word(s.ctrl.bus_id, s.ctrl.par_en,
                                          tsf_pkg::LBL_TIME_US, s.t_us);
         endcase
      end else if (s.cnt != '0) begin
         load_word = s.mem[s.rp];
         pop = |load;
      end else begin
         load_word = tag_word(s.ctrl.bus_id, s.ctrl.par_en, tsf_pkg::LBL_FILL,
                              tsf_pkg::FILL_INFO);
      end

      // -----------------------------------------------------------------
      // frame sequencing
      // -----------------------------------------------------------------
      case (s.st)
         tsf_pkg::ST_IDLE: begin
            next_s.div_cnt = '0;
            next_s.phase = 1'b0;
            next_s.word_bit = '0;
            next_s.word_idx = '0;
            if (s.ctrl.enable) begin
               next_s.st = tsf_pkg::ST_RUN;
            end
         end
         tsf_pkg::ST_RUN: begin
            if (!s.ctrl.enable) begin
               next_s.st = tsf_pkg::ST_IDLE;
            end
            next_s.div_cnt = half_en ? '0 : s.div_cnt + 16'd1;
            if (half_en) begin
               next_s.phase = ~s.phase;
            end
            if (bit_en) begin
               if (s.word_bit == 5'(tsf_pkg::WORD_BITS - 1)) begin
                  next_s.word_bit = '0;
                  // one frame length shared by every track of the bus
                  next_s.word_idx = (s.word_idx == s.frame_len - 9'd1) ? '0 :
                                    s.word_idx + 9'd1;
               end else begin
                  next_s.word_bit = s.word_bit + 5'd1;
               end
            end
         end
         default: begin
            next_s.st = tsf_pkg::ST_IDLE;
         end
      endcase

      // -----------------------------------------------------------------
      // monitor intake: listen only, nothing is ever driven toward the bus
      // -----------------------------------------------------------------
      mon_err = mon_i.err_sync | mon_i.err_manchester | mon_i.err_parity |
                mon_i.err_noncontig | mon_i.err_bitcount;
      case (mon_i.kind)
         tsf_pkg::KIND_CMD: mon_label = mon_i.chan_b ? tsf_pkg::LBL_CMD_B : tsf_pkg::LBL_CMD_A;
         tsf_pkg::KIND_STAT: mon_label = mon_i.chan_b ? tsf_pkg::LBL_STAT_B : tsf_pkg::LBL_STAT_A;
         default: mon_label = mon_i.chan_b ? tsf_pkg::LBL_DATA_B : tsf_pkg::LBL_DATA_A;
      endcase
      if (mon_err) begin
         mon_label = mon_i.chan_b ? tsf_pkg::LBL_ERR_B : tsf_pkg::LBL_ERR_A;
      end

      push = 1'b0;
      push_word = tag_word(s.ctrl.bus_id, s.ctrl.par_en, mon_label, mon_i.info);
      if (s.ovf_pending) begin
         // discontinuity marker goes in as an extra word once room returns
         if (s.cnt < (FIFO_AW + 1)'(FIFO_DEPTH) || pop) begin
            push = 1'b1;
            push_word = tag_word(s.ctrl.bus_id, s.ctrl.par_en, tsf_pkg::LBL_OVF,
                                 tsf_pkg::OVF_INFO);
            next_s.ovf_pending = mon_i.valid;
         end
      end else if (mon_i.valid) begin
         if (s.cnt < (FIFO_AW + 1)'(FIFO_DEPTH) || pop) begin
            push = 1'b1;
         end else begin
            next_s.ovf_pending = 1'b1;
         end
      end
      if (mon_i.valid && mon_err && s.err_cnt != tsf_pkg::ERR_CNT_MAX) begin
         next_s.err_cnt = s.err_cnt + 16'd1;
      end

      // -----------------------------------------------------------------
      // word buffer
      // -----------------------------------------------------------------
      if (push) begin
         next_s.mem[s.wp] = push_word;
         next_s.wp = s.wp + FIFO_AW'(1);
      end
      if (pop) begin
         next_s.rp = s.rp + FIFO_AW'(1);
      end
      next_s.cnt = s.cnt + (FIFO_AW + 1)'(push) - (FIFO_AW + 1)'(pop);

      // -----------------------------------------------------------------
      // register slave
      // -----------------------------------------------------------------
      status = '0;
      status.overflow = s.ovf_sticky;
      status.rate_warn = s.ctrl.scramble &&
                         (int'(s.half_div) + 1 > tsf_pkg::MAX_SCR_HALF_CYCLES);
      status.running = running;
      status.fifo_level = 8'(s.cnt);

      wb_hit = wb_cyc_i && wb_stb_i && !s.ack;
      wb_wr = wb_hit && wb_we_i;
      next_s.ack = wb_hit;
      case ({wb_adr_i[7:2], 2'b00})
         tsf_pkg::ADR_CTRL: cur_reg = 32'(s.ctrl);
         tsf_pkg::ADR_FRAME_LEN: cur_reg = 32'(s.frame_len);
         tsf_pkg::ADR_HALF_DIV: cur_reg = 32'(s.half_div);
         tsf_pkg::ADR_TIME_HI: cur_reg = 32'(s.t_hi);
         tsf_pkg::ADR_TIME_LO: cur_reg = 32'(s.t_lo);
         tsf_pkg::ADR_TIME_US: cur_reg = 32'(s.t_us);
         tsf_pkg::ADR_STATUS: cur_reg = 32'(status);
         tsf_pkg::ADR_ERR_CNT: cur_reg = 32'(s.err_cnt);
         default: cur_reg = 32'h0000_0000;
      endcase
      if (wb_hit) begin
         next_s.rdat = wb_we_i ? 32'h0000_0000 : cur_reg;
      end
      wr_merge = merge(cur_reg, wb_dat_i, wb_sel_i);

      if (mon_i.valid && !push && !s.ovf_pending) begin
         next_s.ovf_sticky = 1'b1;
      end else if (wb_wr && {wb_adr_i[7:2], 2'b00} == tsf_pkg::ADR_STATUS &&
                   wb_sel_i[0] && wb_dat_i[0]) begin
         next_s.ovf_sticky = 1'b0;
      end

      if (wb_wr) begin
         case ({wb_adr_i[7:2], 2'b00})
            tsf_pkg::ADR_CTRL: begin
               next_s.ctrl = wr_merge;
               next_s.ctrl.rsvd_hi = '0;
               next_s.ctrl.rsvd_lo = 1'b0;
            end
            tsf_pkg::ADR_FRAME_LEN: begin
               if (wr_merge[8:0] >= tsf_pkg::FRAME_LEN_MIN &&
                   wr_merge[8:0] <= tsf_pkg::FRAME_LEN_MAX && wr_merge[31:9] == '0) begin
                  next_s.frame_len = wr_merge[8:0];
               end
            end
            tsf_pkg::ADR_HALF_DIV: next_s.half_div = wr_merge[15:0];
            tsf_pkg::ADR_TIME_HI: next_s.t_hi = wr_merge[15:0];
            tsf_pkg::ADR_TIME_LO: next_s.t_lo = wr_merge[15:0];
            tsf_pkg::ADR_TIME_US: next_s.t_us = wr_merge[15:0];
            tsf_pkg::ADR_ERR_CNT: begin
               if (!(mon_i.valid && mon_err)) begin
                  next_s.err_cnt = '0;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '0;
         s.frame_len <= tsf_pkg::FRAME_LEN_RST;
         s.half_div <= tsf_pkg::HALF_DIV_RST;
      end else begin
         s <= next_s;
      end
   end

endmodule // track_spread_formatter

// ### include/tsf_pkg.sv
// constants, register layouts and carrier types of the track spread formatter
// assumes one 50 MHz clock and a same-clock 1553 word decoder feeding the monitor port
package tsf_pkg;

   // -----------------------------------------------------------------
   // geometry and timing
   // -----------------------------------------------------------------
   localparam int MAX_TRACKS = 4;
   localparam int WORD_BITS = 24;
   localparam int CLK_HZ = 50_000_000;
   localparam int MIN_SCR_RATE_BPS = 200_000;
   // half-bit length in clocks above which scrambled rate is below the minimum
   localparam int MAX_SCR_HALF_CYCLES = CLK_HZ / (2 * MIN_SCR_RATE_BPS);

   // -----------------------------------------------------------------
   // word patterns
   // -----------------------------------------------------------------
   localparam logic [23:0] SYNC_WORD = 24'hFA_F320;
   localparam logic [15:0] FILL_INFO = 16'hAAAA;
   localparam logic [15:0] OVF_INFO = 16'h0000;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'h0000;

   // content identification labels
   localparam logic [3:0] LBL_CMD_A = 4'hF;
   localparam logic [3:0] LBL_STAT_A = 4'hE;
   localparam logic [3:0] LBL_DATA_A = 4'hD;
   localparam logic [3:0] LBL_ERR_A = 4'hC;
   localparam logic [3:0] LBL_CMD_B = 4'hB;
   localparam logic [3:0] LBL_STAT_B = 4'hA;
   localparam logic [3:0] LBL_DATA_B = 4'h9;
   localparam logic [3:0] LBL_ERR_B = 4'h8;
   localparam logic [3:0] LBL_TIME_HI = 4'h7;
   localparam logic [3:0] LBL_TIME_LO = 4'h6;
   localparam logic [3:0] LBL_TIME_US = 4'h5;
   localparam logic [3:0] LBL_CRC = 4'h2;
   localparam logic [3:0] LBL_FILL = 4'h1;
   localparam logic [3:0] LBL_OVF = 4'h0;
   localparam int TIME_WORDS = 3;

   // -----------------------------------------------------------------
   // register map (byte offsets) and reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_FRAME_LEN = 8'h04;
   localparam logic [7:0] ADR_HALF_DIV = 8'h08;
   localparam logic [7:0] ADR_TIME_HI = 8'h0C;
   localparam logic [7:0] ADR_TIME_LO = 8'h10;
   localparam logic [7:0] ADR_TIME_US = 8'h14;
   localparam logic [7:0] ADR_STATUS = 8'h18;
   localparam logic [7:0] ADR_ERR_CNT = 8'h1C;

   localparam logic [8:0] FRAME_LEN_RST = 9'h100;
   localparam logic [8:0] FRAME_LEN_MIN = 9'h081;
   localparam logic [8:0] FRAME_LEN_MAX = 9'h1FF;
   localparam logic [15:0] HALF_DIV_RST = 16'h0031;
   localparam logic [15:0] ERR_CNT_MAX = 16'hFFFF;

   // -----------------------------------------------------------------
   // carrier types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [19:0] rsvd_hi;
      logic [3:0] bus_id;
      logic rsvd_lo;
      logic par_en;
      logic scramble;
      logic crc_en;
      logic ft_en;
      logic [1:0] tk_m1;
      logic enable;
   } ctrl_reg_t;

   typedef struct packed {
      logic [15:0] rsvd_hi;
      logic [7:0] fifo_level;
      logic [4:0] rsvd_lo;
      logic running;
      logic rate_warn;
      logic overflow;
   } status_reg_t;

   typedef enum logic [1:0] {
      KIND_CMD = 2'b00,
      KIND_STAT = 2'b01,
      KIND_DATA = 2'b10
   } mon_kind_t;

   // decoded word from the bus receiver, sync and parity already removed
   typedef struct packed {
      logic valid;
      logic chan_b;
      mon_kind_t kind;
      logic err_sync;
      logic err_manchester;
      logic err_parity;
      logic err_noncontig;
      logic err_bitcount;
      logic [15:0] info;
   } mon_word_t;

   typedef struct packed {
      logic [3:0] ident;
      logic [3:0] label;
      logic [15:0] info;
   } tagged_word_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01
   } run_state_t;

endpackage

// ### sim/track_recorder_model.sv
// recorder side: decodes bi-phase tracks back into 24-bit words
// assumes the bit clock is low in the first half of each cell
module track_recorder_model (
   input wire logic clk_i,
   input wire logic bit_clk_i,
   input wire logic [3:0] line_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] words[4][$];
   logic [23:0] win[4];
   logic lock[4] = '{default: 1'b0};
   int sync_t[4];
   int nbit[4];
   int cyc = 0;
   logic prev = 1'b0;
   always @(posedge clk_i) begin
      cyc++;
      if (!prev && bit_clk_i) begin
         for (int k = 0; k < 4; k++) begin
            // second half carries the inverse of the bit
            win[k] = {win[k][22:0], ~line_i[k]};
            if (!lock[k] && win[k] === 24'hFA_F320) begin
               lock[k] = 1'b1;
               sync_t[k] = cyc;
               nbit[k] = 0;
            end
            if (lock[k] && nbit[k] % 24 == 0) words[k].push_back(win[k]);
            nbit[k]++;
         end
      end
      prev = bit_clk_i;
   end
endmodule // track_recorder_model

// ### sim/track_spread_formatter_properties.sv
// checker of bus answers and overflow flag at the formatter ports
// assumes a single clock domain and bind to every formatter instance
module track_spread_formatter_properties (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire tsf_pkg::mon_word_t mon_i,
   input wire logic overflow_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire logic rd = wb_ack_o && !wb_we_i;
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack; s_req |=> s_ans; endproperty
   a_ack: assert property (p_ack) else $error("ack not a one-cycle pulse");
   property p_wr_dat; wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0000_0000; endproperty
   a_wr_dat: assert property (p_wr_dat) else $error("write ack with data");
   property p_status;
      rd && wb_adr_i[7:2] == tsf_pkg::ADR_STATUS[7:2] |-> wb_dat_o[0] == $past(overflow_o);
   endproperty
   a_status: assert property (p_status) else $error("status bit differs from pin");
   property p_ctrl_rsvd;
      rd && wb_adr_i[7:2] == 6'h00 |-> wb_dat_o[31:12] == 20'h0_0000 && !wb_dat_o[7];
   endproperty
   a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved control bits set");
   property p_unmapped; rd && wb_adr_i[7:5] != 3'b000 |-> wb_dat_o == 32'h0000_0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_frame_len;
      rd && wb_adr_i[7:2] == 6'h01 |-> wb_dat_o[8:0] inside {[9'h081:9'h1FF]}
         && wb_dat_o[31:9] == 23'h00_0000;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length out of range");
   property p_ovf_rise; $rose(overflow_o) |-> $past(mon_i.valid); endproperty
   a_ovf_rise: assert property (p_ovf_rise) else $error("overflow without word");
   property p_ovf_hold; overflow_o && !(wb_cyc_i && wb_we_i) |=> overflow_o; endproperty
   a_ovf_hold: assert property (p_ovf_hold) else $error("overflow not sticky");
endmodule // track_spread_formatter_properties

bind track_spread_formatter track_spread_formatter_properties u_props (.clk_i(clk_i),
   .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .mon_i(mon_i),
   .overflow_o(overflow_o));

// ### sim/track_spread_formatter_test.sv
// self-checking bench: registers, monitor words in, decoded tracks out
// assumes bi-phase tracks decoded by the recorder model
module track_spread_formatter_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, bit_clk_o, overflow_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic [3:0] track_line_o;
   tsf_pkg::mon_word_t mon_i = '0;
   logic [23:0] exp_q[$], e, got;
   logic [15:0] tm[3], crc;
   logic [7:0] radr[6] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1C, 8'h20};
   int errors = 0, checks = 0, n_err = 0, n, s;
   always #10 clk_i = ~clk_i;
   track_spread_formatter u_track_spread_formatter (.clk_i(clk_i), .resetn_i(resetn_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
      .mon_i(mon_i), .track_line_o(track_line_o), .bit_clk_o(bit_clk_o),
      .overflow_o(overflow_o));
   track_recorder_model u_track_recorder_model (.clk_i(clk_i), .bit_clk_i(bit_clk_o),
      .line_i(track_line_o));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int k;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (wb_ack_o !== 1'b1) begin
         errors++;
         summarize();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic send(input int cnt);
      tsf_pkg::mon_word_t m;
      repeat (cnt) begin
         m = '0;
         m.valid = 1'b1;
         m.chan_b = 1'($urandom);
         m.kind = tsf_pkg::mon_kind_t'($urandom_range(2));
         if ($urandom_range(3) == 0) m[16 + $urandom_range(4)] = 1'b1;
         m.info = 16'($urandom);
         if (|m[20:16]) n_err++;
         e = {4'h3, m.kind == 2'b00 ? 4'hF : m.kind == 2'b01 ? 4'hE : 4'hD, m.info};
         if (|m[20:16]) e[19:16] = 4'hC;
         // secondary channel labels sit four below the primary ones
         if (m.chan_b) e[19:16] = e[19:16] - 4'h4;
         exp_q.push_back(e);
         @(posedge clk_i);
         mon_i <= m;
      end
      @(posedge clk_i);
      mon_i <= '0;
   endtask
   initial begin
      void'($urandom(32'h8213_5aaa));
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      foreach (radr[i]) begin
         wb(1'b0, radr[i], 32'h0000_0000);
         chk("reset value", rd, i == 1 ? 32'h0000_0100 : i == 2 ? 32'h0000_0031 : 32'h0);
      end
      wb(1'b1, tsf_pkg::ADR_FRAME_LEN, 32'h0000_0080);
      wb(1'b0, tsf_pkg::ADR_FRAME_LEN, 32'h0000_0000);
      chk("short frame refused", rd, 32'h0000_0100);
      wb(1'b1, tsf_pkg::ADR_FRAME_LEN, 32'h0000_0081);
      wb(1'b1, tsf_pkg::ADR_CTRL, 32'h0000_0320);
      for (int i = 0; i < 2; i++) begin
         wb(1'b1, tsf_pkg::ADR_HALF_DIV, 32'h0000_007C + i);
         wb(1'b0, tsf_pkg::ADR_STATUS, 32'h0000_0000);
         chk("rate warning", rd[1], i);
      end
      for (int i = 0; i < 3; i++) begin
         tm[i] = 16'($urandom);
         wb(1'b1, tsf_pkg::ADR_TIME_HI + 8'(4 * i), {16'h0000, tm[i]});
      end
      wb(1'b1, tsf_pkg::ADR_HALF_DIV, 32'h0000_0001);
      send(12);
      wb(1'b0, tsf_pkg::ADR_ERR_CNT, 32'h0000_0000);
      chk("error count", rd, n_err);
      $display("test registers done");
      wb(1'b1, tsf_pkg::ADR_CTRL, 32'h0000_031F);
      n = 0;
      while (u_track_recorder_model.words[3].size() < 130 && n < 20000) begin
         @(posedge clk_i);
         n++;
      end
      if (u_track_recorder_model.words[3].size() < 130) begin
         errors++;
         summarize();
      end
      for (int k = 0; k < 4; k++) begin
         chk("words", u_track_recorder_model.words[k].size() >= 130, 1);
         crc = 16'h0000;
         for (int w = 0; w < 129; w++) begin
            s = (w - 1) * 4 + k;
            got = u_track_recorder_model.words[k][w];
            e = 24'h31_AAAA;
            if (s >= 3 && s - 3 < exp_q.size()) e = exp_q[s - 3];
            if (s >= 0 && s < 3) e = {4'h3, 4'(7 - s), tm[s]};
            if (w == 0) e = 24'hFA_F320;
            if (w == 128) e = {8'h32, crc};
            chk("track word", got, e);
            if (w > 0 && w < 128)
               for (int b = 23; b >= 0; b--)
                  crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ e[b]) ? 16'h8005 : 16'h0000);
         end
         chk("next sync", u_track_recorder_model.words[k][129], 24'hFA_F320);
         chk("stagger", u_track_recorder_model.sync_t[k] - u_track_recorder_model.sync_t[0],
            k * 24);
      end
      $display("test frame done");
      send(20);
      chk("overflow pin", overflow_o, 1);
      wb(1'b1, tsf_pkg::ADR_STATUS, 32'h0000_0001);
      wb(1'b0, tsf_pkg::ADR_STATUS, 32'h0000_0000);
      chk("overflow cleared", rd[0], 0);
      $display("test overflow done");
      summarize();
   end
endmodule // track_spread_formatter_test
